// File: design/igmps_pkg.sv
// Package for the IGMP snooping multicast filter: constants and carrier types.
// Assumes one switch clock at 25 MHz and parsed IPv4 words arriving as a stream.
// Overview of operation
// - Every recognised IGMP message is copied to the management processor.
// - With snooping on, multicast frames other than to 224.0.0.1 go only to recorded member ports.
// - Type 0x11 with group zero is general query, otherwise group-specific.
// - Types 0x16 and 0x12 are reports that add the receiving port.
// - Type 0x17 is a version 2 leave for the named group.
// - A group unanswered for its timeout loses members and stops forwarding.
// - Exactly one querier is elected per LAN.
// - Only destinations 224.0.0.0 to 239.255.255.255 count as multicast groups.
// - A control switches all snooping on or off; off means no filtering.
// - A separate control enables the switch's own periodic queries.
// - Fast leave removes the port at once without a group query.
package igmps_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PORTS = 26;
  localparam int unsigned ENTRIES = 8;

  localparam logic [7:0] TYPE_QUERY = 8'h11;
  localparam logic [7:0] TYPE_REPORT_V2 = 8'h16;
  localparam logic [7:0] TYPE_LEAVE_V2 = 8'h17;
  localparam logic [7:0] TYPE_REPORT_V1 = 8'h12;
  localparam logic [31:0] ALL_HOSTS = 32'hE0000001;
  localparam logic [3:0] MCAST_PREFIX = 4'hE;
  localparam logic [7:0] QUERY_TTL = 8'h01;

  // Timing figures in seconds; only the query interval is turned into cycles below, the timeouts stay in one-second ticks.
  localparam int unsigned QUERY_INTERVAL_S = 125;
  localparam int unsigned MEMBER_TIMEOUT_S = 260;
  localparam int unsigned LEAVE_TIMEOUT_S = 2;
  localparam int unsigned QUERY_INTERVAL_CYC = QUERY_INTERVAL_S * CLK_HZ;
  localparam int unsigned MEMBER_TIMEOUT_CYC = MEMBER_TIMEOUT_S;
  localparam int unsigned LEAVE_TIMEOUT_CYC = LEAVE_TIMEOUT_S;
  localparam int unsigned TICK_CYC = CLK_HZ;

  typedef logic [PORTS-1:0] igmps_mask_t;

  typedef struct packed {
    logic [31:0] group;
    logic [11:0] vid;
    logic [4:0] port;
    logic [7:0] msg_type;
    logic [7:0] resp_time;
    logic [15:0] checksum;
  } igmps_msg_s;

  typedef struct packed {
    logic valid;
    logic [31:0] group;
    logic [11:0] vid;
    igmps_mask_t members;
    logic [8:0] age;
    igmps_mask_t pend;
    logic [1:0] pend_age;
  } igmps_entry_s;

  typedef struct packed {
    logic [31:0] group;
    logic [11:0] vid;
    logic [7:0] ttl;
    igmps_mask_t ports;
  } igmps_query_s;

  typedef enum logic [1:0] {PS_W0, PS_W1} igmps_parse_e;

endpackage : igmps_pkg

// File: design/igmps_fifo.sv
// Synchronous valid/ready FIFO carrying captured IGMP messages to the CPU.
// Assumes the same clock and reset as the snooping filter.
`timescale 1ns/1ps
module igmps_fifo
  import igmps_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } igmps_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  igmps_fifo_s st_r;
  igmps_fifo_s st_nxt;
  logic push;
  logic pop;

  assign o_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign o_valid = (st_r.cnt != '0);
  assign o_data = mem[st_r.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem[st_r.wp] <= i_data;
    end
  end

endmodule : igmps_fifo

// File: design/igmps_filter.sv
// IGMP snooping and multicast forwarding filter.
// Assumes IGMP payload words and frame lookups arrive from the switch pipeline
// on the same clock; configuration levels come from management logic.
`timescale 1ns/1ps
module igmps_filter
  import igmps_pkg::*;
#(
  parameter int unsigned N_ENTRIES = ENTRIES,
  parameter int unsigned QUERY_CYC = QUERY_INTERVAL_CYC,
  parameter int unsigned TICK = TICK_CYC,
  parameter int unsigned DEPTH = 16
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Configuration levels
  input wire logic i_snoop_en,
  input wire logic i_querier_en,
  input wire logic i_fast_leave_en,
  input wire logic i_querier_elected,
  // IGMP payload stream: two words per message
  input wire logic i_igmp_valid,
  output logic o_igmp_ready,
  input wire logic i_igmp_last,
  input wire logic [31:0] i_igmp_word,
  input wire logic [11:0] i_igmp_vid,
  input wire logic [4:0] i_igmp_port,
  // Copy to management processor
  output logic o_cpu_valid,
  input wire logic i_cpu_ready,
  output igmps_msg_s o_cpu_msg,
  // Forwarding lookup
  input wire logic i_fwd_valid,
  input wire logic [31:0] i_fwd_dip,
  input wire logic [11:0] i_fwd_vid,
  input wire igmps_mask_t i_fwd_flood,
  output logic o_fwd_valid,
  output igmps_mask_t o_fwd_mask,
  // Query request to the frame generator
  output logic o_query_valid,
  input wire logic i_query_ready,
  output igmps_query_s o_query
);
  typedef struct packed {
    igmps_parse_e ps;
    logic [31:0] w0;
    logic msg_valid;
    igmps_msg_s msg;
    logic [31:0] qcnt;
    logic [31:0] tick;
    logic tick_p;
    logic q_valid;
    igmps_query_s q;
    logic f_valid;
    igmps_mask_t f_mask;
    igmps_entry_s [N_ENTRIES-1:0] tab;
  } igmps_state_s;

  igmps_state_s st_r;
  igmps_state_s st_nxt;
  logic fifo_ready;

  function automatic logic is_mcast(input logic [31:0] a);
    return a[31:28] == MCAST_PREFIX;
  endfunction : is_mcast

  function automatic igmps_mask_t bit_of(input logic [4:0] p);
    return igmps_mask_t'(1) << p;
  endfunction : bit_of

  assign o_igmp_ready = fifo_ready;

  igmps_fifo #(.WIDTH($bits(igmps_msg_s)), .DEPTH(DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_valid(st_r.msg_valid),
    .o_ready(fifo_ready),
    .i_data(st_r.msg),
    .o_valid(o_cpu_valid),
    .i_ready(i_cpu_ready),
    .o_data(o_cpu_msg)
  );

  assign o_fwd_valid = st_r.f_valid;
  assign o_fwd_mask = st_r.f_mask;
  assign o_query_valid = st_r.q_valid;
  assign o_query = st_r.q;

  always_comb
  begin
    logic hit;
    logic free_found;
    int unsigned free_ix;
    igmps_mask_t pm;
    logic [7:0] t;
    hit = 1'b0;
    free_found = 1'b0;
    free_ix = 0;
    pm = '0;
    t = '0;
    st_nxt = st_r;
    st_nxt.msg_valid = 1'b0;
    st_nxt.tick_p = 1'b0;
    if (st_r.tick == TICK - 1)
    begin
      st_nxt.tick = '0;
      st_nxt.tick_p = 1'b1;
    end
    else
    begin
      st_nxt.tick = st_r.tick + 32'h1;
    end
    // Parse the two payload words; stall while the CPU copy queue is full.
    if (i_igmp_valid && fifo_ready)
    begin
      unique case (st_r.ps)
        PS_W0:
        begin
          st_nxt.w0 = i_igmp_word;
          if (!i_igmp_last)
          begin
            st_nxt.ps = PS_W1;
          end
        end
        PS_W1:
        begin
          st_nxt.ps = PS_W0;
          st_nxt.msg_valid = 1'b1;
          st_nxt.msg.msg_type = st_r.w0[7:0];
          st_nxt.msg.resp_time = st_r.w0[15:8];
          st_nxt.msg.checksum = st_r.w0[31:16];
          st_nxt.msg.group = i_igmp_word;
          st_nxt.msg.vid = i_igmp_vid;
          st_nxt.msg.port = i_igmp_port;
        end
      endcase
    end
    // Ageing: one step per second tick.
    for (int i = 0; i < N_ENTRIES; i++)
    begin
      if (st_r.tab[i].valid && st_r.tick_p)
      begin
        if (st_r.tab[i].age == 9'(MEMBER_TIMEOUT_CYC))
        begin
          st_nxt.tab[i].valid = 1'b0;
          st_nxt.tab[i].members = '0;
        end
        else
        begin
          st_nxt.tab[i].age = st_r.tab[i].age + 9'h1;
        end
        if (st_r.tab[i].pend != '0)
        begin
          if (st_r.tab[i].pend_age == 2'(LEAVE_TIMEOUT_CYC))
          begin
            st_nxt.tab[i].members = st_r.tab[i].members & ~st_r.tab[i].pend;
            st_nxt.tab[i].pend = '0;
          end
          else
          begin
            st_nxt.tab[i].pend_age = st_r.tab[i].pend_age + 2'h1;
          end
        end
      end
    end
    // The standing query is released first so that a new one may follow it at once.
    if (st_r.q_valid && i_query_ready)
    begin
      st_nxt.q_valid = 1'b0;
    end
    // Membership update from the message just captured.
    if (st_r.msg_valid && i_snoop_en)
    begin
      t = st_r.msg.msg_type;
      pm = bit_of(st_r.msg.port);
      for (int i = 0; i < N_ENTRIES; i++)
      begin
        if (st_r.tab[i].valid && st_r.tab[i].group == st_r.msg.group
            && st_r.tab[i].vid == st_r.msg.vid)
        begin
          hit = 1'b1;
          if (t == TYPE_REPORT_V2 || t == TYPE_REPORT_V1)
          begin
            // A report in the cycle that ages the entry out keeps it alive.
            st_nxt.tab[i].valid = 1'b1;
            st_nxt.tab[i].members = st_nxt.tab[i].members | pm;
            st_nxt.tab[i].pend = st_nxt.tab[i].pend & ~pm;
            st_nxt.tab[i].age = '0;
          end
          else if (t == TYPE_LEAVE_V2 && i_fast_leave_en)
          begin
            st_nxt.tab[i].members = st_nxt.tab[i].members & ~pm;
          end
          else if (t == TYPE_LEAVE_V2)
          begin
            st_nxt.tab[i].pend = st_nxt.tab[i].pend | pm;
            st_nxt.tab[i].pend_age = '0;
            // A query still waiting for the frame generator is never overwritten; the
            // port then simply ages out after the leave timeout.
            if (!st_nxt.q_valid)
            begin
              st_nxt.q_valid = 1'b1;
              st_nxt.q.group = st_r.msg.group;
              st_nxt.q.vid = st_r.msg.vid;
              st_nxt.q.ttl = QUERY_TTL;
              st_nxt.q.ports = pm;
            end
          end
        end
        else if (!st_r.tab[i].valid && !free_found)
        begin
          free_found = 1'b1;
          free_ix = i;
        end
      end
      // Queries (0x11) only refresh nothing; general versus specific is told by group.
      if (!hit && free_found && is_mcast(st_r.msg.group)
          && (t == TYPE_REPORT_V2 || t == TYPE_REPORT_V1))
      begin
        st_nxt.tab[free_ix].valid = 1'b1;
        st_nxt.tab[free_ix].group = st_r.msg.group;
        st_nxt.tab[free_ix].vid = st_r.msg.vid;
        st_nxt.tab[free_ix].members = pm;
        st_nxt.tab[free_ix].age = '0;
        st_nxt.tab[free_ix].pend = '0;
      end
    end
    // Periodic general query, only while enabled and elected.
    if (i_querier_en && i_querier_elected)
    begin
      if (st_r.qcnt >= QUERY_CYC - 1)
      begin
        st_nxt.qcnt = '0;
        if (!st_nxt.q_valid)
        begin
          st_nxt.q_valid = 1'b1;
          st_nxt.q.group = 32'h0;
          st_nxt.q.vid = '0;
          st_nxt.q.ttl = QUERY_TTL;
          st_nxt.q.ports = '1;
        end
      end
      else
      begin
        st_nxt.qcnt = st_r.qcnt + 32'h1;
      end
    end
    else
    begin
      st_nxt.qcnt = '0;
    end
    // Forwarding decision, one cycle after the lookup.
    st_nxt.f_valid = i_fwd_valid;
    st_nxt.f_mask = i_fwd_flood;
    if (i_snoop_en && is_mcast(i_fwd_dip) && i_fwd_dip != ALL_HOSTS)
    begin
      st_nxt.f_mask = '0;
      for (int i = 0; i < N_ENTRIES; i++)
      begin
        if (st_r.tab[i].valid && st_r.tab[i].group == i_fwd_dip
            && st_r.tab[i].vid == i_fwd_vid)
        begin
          st_nxt.f_mask = i_fwd_flood & st_r.tab[i].members;
        end
      end
    end
    if (!i_snoop_en)
    begin
      for (int i = 0; i < N_ENTRIES; i++)
      begin
        st_nxt.tab[i].valid = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : igmps_filter

// File: test/igmps_filter_monitor.sv
// Port checker of the IGMP snooping filter.
// Assumes the single clock and reset of igmps_filter.
`timescale 1ns/1ps
module igmps_filter_monitor
  import igmps_pkg::*;
(
  // Clock, reset and levels
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_snoop_en,
  input wire logic i_querier_en,
  // Streams
  input wire logic i_igmp_valid,
  input wire logic o_igmp_ready,
  input wire logic i_igmp_last,
  input wire logic o_cpu_valid,
  input wire logic i_cpu_ready,
  input wire igmps_msg_s o_cpu_msg,
  input wire logic i_fwd_valid,
  input wire logic [31:0] i_fwd_dip,
  input wire igmps_mask_t i_fwd_flood,
  input wire logic o_fwd_valid,
  input wire igmps_mask_t o_fwd_mask,
  input wire logic o_query_valid,
  input wire logic i_query_ready,
  input wire igmps_query_s o_query
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  AST_FWD_LAT: assert property (i_fwd_valid |=> o_fwd_valid)
    else $error("Lookup answer missing.");
  AST_FWD_ONE: assert property (!i_fwd_valid |=> !o_fwd_valid)
    else $error("Unrequested lookup answer.");
  AST_FWD_SUBSET: assert property (o_fwd_valid |-> (o_fwd_mask & ~$past(i_fwd_flood)) == '0)
    else $error("Mask outside flood set.");
  AST_SNOOP_OFF: assert property (i_fwd_valid && !i_snoop_en |=> o_fwd_mask == $past(i_fwd_flood))
    else $error("Filtering while snooping is off.");
  AST_NOT_GROUP: assert property (i_fwd_valid && i_fwd_dip[31:28] != 4'hE
    |=> o_fwd_mask == $past(i_fwd_flood))
    else $error("Non-group address filtered.");
  AST_CPU_LAT: assert property (i_igmp_valid && o_igmp_ready && i_igmp_last && !o_cpu_valid
    |-> ##[1:3] o_cpu_valid)
    else $error("Message copy late.");
  AST_CPU_HOLD: assert property (o_cpu_valid && !i_cpu_ready |=> o_cpu_valid && $stable(o_cpu_msg))
    else $error("Copy dropped while stalled.");
  AST_QRY_HOLD: assert property (o_query_valid && !i_query_ready
    |=> o_query_valid && $stable(o_query))
    else $error("Query dropped while stalled.");
  AST_QRY_TTL: assert property (o_query_valid |-> o_query.ttl == 8'h01)
    else $error("Query hop limit wrong.");
  AST_QRY_GEN: assert property ($rose(o_query_valid) && o_query.group == '0 |-> $past(i_querier_en))
    else $error("General query while disabled.");
  COV_FWD: cover property (o_fwd_valid && o_fwd_mask != '0 && o_fwd_mask != $past(i_fwd_flood));
  COV_CPU_STALL: cover property (o_cpu_valid && !i_cpu_ready ##1 o_cpu_valid && i_cpu_ready);
  COV_QRY: cover property (o_query_valid && !i_query_ready ##1 i_query_ready);
endmodule : igmps_filter_monitor

bind igmps_filter igmps_filter_monitor u_mon (.*);

// File: test/igmps_host_model.sv
// Model of multicast hosts and routers on the switch ports.
// Assumes the bench calls send and shares the switch clock.
`timescale 1ns/1ps
module igmps_host_model
(
  input wire logic i_clock,
  input wire logic i_ready,
  input wire logic i_slow,
  output logic o_valid,
  output logic o_last,
  output logic [31:0] o_word,
  output logic [11:0] o_vid,
  output logic [4:0] o_port,
  output logic o_query_ready
);
  logic [2:0] stall_r = 3'h0;
  initial
  begin
    o_valid = 1'b0;
    o_last = 1'b0;
    o_word = 32'h0;
    o_vid = 12'h0;
    o_port = 5'h0;
  end
  always @(posedge i_clock)
    stall_r <= stall_r + 3'h1;
  // A slow router takes queries only in half of each eight-cycle round.
  assign o_query_ready = !i_slow || stall_r[2];
  // Reports, leaves and router queries; version 1 hosts never leave loudly.
  task automatic send(input logic [7:0] t, input logic [31:0] g, input logic [4:0] p,
                      input logic [11:0] v);
    @(posedge i_clock);
    o_valid <= 1'b1;
    o_last <= 1'b0;
    o_word <= {g[15:0] ^ 16'h5A5A, 8'h64, t};
    do @(posedge i_clock); while (!i_ready);
    o_last <= 1'b1;
    o_word <= g;
    o_vid <= v;
    o_port <= p;
    do @(posedge i_clock); while (!i_ready);
    // Released lines show the inverse so stale data is never mistaken for valid.
    o_valid <= 1'b0;
    o_last <= 1'b0;
    o_word <= ~g;
    o_vid <= ~v;
    o_port <= ~p;
  endtask : send
endmodule : igmps_host_model

// File: test/tb.sv
// Self-checking bench of the IGMP snooping filter.
// Assumes the filter, its FIFO, the host model and the monitor are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb
  import igmps_pkg::*;
;
  localparam logic [31:0] G1 = 32'hEFFFFFFA;
  localparam logic [31:0] G2 = 32'hE0000105;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic snoop_en = 1'b0, querier_en = 1'b0, fast_en = 1'b0, elected = 1'b0;
  logic cpu_ready = 1'b0, cpu_hold = 1'b0, fwd_valid = 1'b0, slow = 1'b0;
  logic [31:0] fwd_dip = 32'h0;
  logic [11:0] fwd_vid = 12'h0;
  igmps_mask_t fwd_flood = '0;
  logic [15:0] lfsr_r = 16'hB14C;
  int fail_count = 0, checks_done = 0;
  igmps_msg_s exp_q[$];
  igmps_msg_s exp_m, cpu_msg;
  igmps_mask_t fwd_mask;
  igmps_query_s query;
  wire igmp_valid, igmp_ready, igmp_last, cpu_valid, fwd_out, query_valid, query_ready;
  wire [31:0] igmp_word;
  wire [11:0] igmp_vid;
  wire [4:0] igmp_port;
  igmps_filter #(.N_ENTRIES(8), .QUERY_CYC(100), .TICK(10), .DEPTH(16)) dut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_snoop_en(snoop_en),
    .i_querier_en(querier_en), .i_fast_leave_en(fast_en), .i_querier_elected(elected),
    .i_igmp_valid(igmp_valid), .o_igmp_ready(igmp_ready), .i_igmp_last(igmp_last),
    .i_igmp_word(igmp_word), .i_igmp_vid(igmp_vid), .i_igmp_port(igmp_port),
    .o_cpu_valid(cpu_valid), .i_cpu_ready(cpu_ready), .o_cpu_msg(cpu_msg),
    .i_fwd_valid(fwd_valid), .i_fwd_dip(fwd_dip), .i_fwd_vid(fwd_vid),
    .i_fwd_flood(fwd_flood), .o_fwd_valid(fwd_out), .o_fwd_mask(fwd_mask),
    .o_query_valid(query_valid), .i_query_ready(query_ready), .o_query(query));
  igmps_host_model host (.i_clock(i_clock), .i_ready(igmp_ready), .i_slow(slow),
    .o_valid(igmp_valid), .o_last(igmp_last), .o_word(igmp_word), .o_vid(igmp_vid),
    .o_port(igmp_port), .o_query_ready(query_ready));
  initial
  begin
    forever #20 i_clock = ~i_clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic igmps_mask_t exp_fwd(input logic [31:0] d, input igmps_mask_t fl,
                                          input igmps_mask_t mem);
    return (!snoop_en || d[31:28] != 4'hE) ? fl : (fl & mem);
  endfunction : exp_fwd
  always @(posedge i_clock)
  begin
    lfsr_r <= lfsr(lfsr_r);
    cpu_ready <= !cpu_hold && lfsr_r[0];
    if (i_reset_n && cpu_valid && cpu_ready)
    begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0)
      begin
        exp_m = exp_q.pop_front();
        `CHK(cpu_msg, exp_m)
      end
    end
  end
  task automatic tx(input logic [7:0] t, input logic [31:0] g, input logic [4:0] p,
                    input logic [11:0] v);
    exp_q.push_back('{g, v, p, t, 8'h64, g[15:0] ^ 16'h5A5A});
    host.send(t, g, p, v);
  endtask : tx
  task automatic look(input logic [31:0] d, input logic [11:0] v, input igmps_mask_t mem);
    @(posedge i_clock);
    fwd_valid <= 1'b1;
    fwd_dip <= d;
    fwd_vid <= v;
    fwd_flood <= {lfsr_r, lfsr_r[9:0]};
    @(posedge i_clock);
    fwd_valid <= 1'b0;
    #1;
    `CHK(fwd_out, 1'b1)
    `CHK(fwd_mask, exp_fwd(d, fwd_flood, mem))
  endtask : look
  task automatic no_query(input int n);
    repeat (n)
    begin
      @(posedge i_clock);
      #1;
      `CHK(query_valid, 1'b0)
    end
  endtask : no_query
  task automatic wait_query(input logic [31:0] g, input igmps_mask_t pm, input logic [11:0] v,
                            input int lim);
    int n;
    n = 0;
    while (!(query_valid && query_ready) && n < lim)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    `CHK(query_valid, 1'b1)
    `CHK(query.group, g)
    `CHK(query.ports, pm)
    `CHK(query.vid, v)
    `CHK(query.ttl, 8'h01)
    @(posedge i_clock);
  endtask : wait_query
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    #(20000 * 40);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    look(G1, 12'h005, '0);
    snoop_en <= 1'b1;
    tx(TYPE_REPORT_V2, G1, 5'd3, 12'h005);
    tx(TYPE_REPORT_V2, G1, 5'd7, 12'h005);
    tx(TYPE_REPORT_V1, G1, 5'd9, 12'h005);
    repeat (4) @(posedge i_clock);
    look(G1, 12'h005, 26'h288);
    look(G1, 12'h006, '0);
    look({4'h1, lfsr_r, 12'h0}, 12'h005, '0);
    look(32'hF0000001, 12'h005, '0);
    while (exp_q.size() != 0) @(posedge i_clock);
    cpu_hold <= 1'b1;
    for (int i = 0; i < 16; i++)
      tx(TYPE_QUERY, (i == 15) ? G2 : 32'h0, i[4:0], 12'h001);
    repeat (4) @(posedge i_clock);
    #1;
    `CHK(igmp_ready, 1'b0)
    cpu_hold <= 1'b0;
    repeat (80) @(posedge i_clock);
    `CHK(exp_q.size() == 0, 1'b1)
    fast_en <= 1'b1;
    tx(TYPE_LEAVE_V2, G1, 5'd3, 12'h005);
    no_query(6);
    look(G1, 12'h005, 26'h280);
    fast_en <= 1'b0;
    tx(TYPE_LEAVE_V2, G1, 5'd7, 12'h005);
    wait_query(G1, 26'h80, 12'h005, 20);
    look(G1, 12'h005, 26'h280);
    repeat (40) @(posedge i_clock);
    look(G1, 12'h005, 26'h200);
    tx(TYPE_REPORT_V2, G2, 5'd2, 12'h00A);
    repeat (2450) @(posedge i_clock);
    look(G2, 12'h00A, 26'h4);
    repeat (300) @(posedge i_clock);
    look(G2, 12'h00A, '0);
    slow <= 1'b1;
    querier_en <= 1'b1;
    no_query(250);
    elected <= 1'b1;
    wait_query(32'h0, '1, 12'h000, 250);
    querier_en <= 1'b0;
    repeat (10) @(posedge i_clock);
    no_query(250);
    end_of_test();
  end
endmodule : tb
